/* File: hdl/health_responder.sv */
// Purpose: Device-side responder for the drive-health subcommands
// Assumes: Task file strobe and values come from logic on mclk
// Notes: One command at a time; new strobes are ignored while busy
// Functional notes
// - Threshold sector: version, thirty entries, checksum
// - Spare entry: C4h, threshold, zero rest
// - Erase entry: E5h, threshold, zero rest
// - Four entries: identifier then zero threshold
// - Exceeded condition loads F4h and 2Ch
// - Healthy status loads 4Fh and C2h
// - Remap returns one sector, count one
// - Remap: initial counts, current counts, reserved
// - Wear data: four sectors, 1024 classes
// - Sector n word k is class 256n+k
// - Erase past threshold multiple moves class
// - Classes 0-1022 levelled, 1023 exempt
// - Exceeded when attribute below its threshold
module health_responder
  import health_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic ce,
  // Task file command
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_opcode,
  input wire logic [7:0] cmd_feature,
  input wire logic [7:0] cmd_cyl_lo,
  input wire logic [7:0] cmd_cyl_hi,
  input wire logic [7:0] cmd_sector_count,
  // Status answer
  output logic status_load,
  output logic [7:0] cyl_lo_out,
  output logic [7:0] cyl_hi_out,
  output logic cmd_abort,
  output logic busy,
  // Data sector stream
  output logic [7:0] dout,
  output logic dout_valid,
  input wire logic dout_ready,
  output logic sector_end,
  // Attribute values and thresholds
  input wire logic [7:0] spare_value,
  input wire logic [7:0] spare_threshold,
  input wire logic [7:0] erase_value,
  input wire logic [7:0] erase_threshold,
  // Spare block counts per chip
  input wire logic [15:0] spare_init [CHIPS],
  input wire logic [15:0] spare_cur [CHIPS],
  // Wear-level events
  input wire logic [15:0] wear_threshold,
  input wire logic blk_place,
  input wire logic [9:0] blk_place_class,
  input wire logic blk_erase,
  input wire logic [9:0] blk_class,
  input wire logic [31:0] blk_erase_count,
  output logic blk_moved
);
  typedef enum {IDLE, SEND} state_t;
  typedef enum {SRC_THR, SRC_REMAP, SRC_WEAR} src_t;

  state_t state;
  src_t src;
  logic [8:0] byte_idx;
  logic [1:0] sector_idx;
  logic [1:0] sector_last;
  logic [4:0] ent;
  logic [3:0] ent_off;
  logic [7:0] sum;
  logic [15:0] hist [CLASSES];
  logic exceeded;
  logic step;
  logic accept;
  logic take;
  logic [7:0] next_byte;

  // All checks below run on mclk and rest during reset
  default clocking cb_chk @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  // Entry byte for the threshold sector, by entry number and offset
  function automatic logic [7:0] thr_entry(input logic [4:0] e,
                                            input logic [3:0] o,
                                            input logic [7:0] sthr,
                                            input logic [7:0] ethr);
    logic [7:0] id;
    logic [7:0] val;
    id = 8'h00;
    val = 8'h00;
    case (e)
      5'h00: begin
        id = ID_SPARE;
        val = sthr;
      end
      5'h01: begin
        id = ID_ERASE;
        val = ethr;
      end
      5'h02: id = ID_ECC_TOTAL;
      5'h03: id = ID_ECC_CORR;
      5'h04: id = ID_READS;
      5'h05: id = ID_UDMA_CRC;
      default: id = 8'h00;
    endcase
    if (o == 4'h0) begin
      return id;
    end else if (o == 4'h1) begin
      return val;
    end
    return 8'h00;
  endfunction : thr_entry

  // Low or high byte of a 16-bit word by the byte index parity
  function automatic logic [7:0] half(input logic [15:0] w,
                                      input logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction : half

  wear_class_step u_step (
    .erase_count(blk_erase_count),
    .cur_class(blk_class),
    .wear_threshold(wear_threshold),
    .step(step)
  );

  assign exceeded = (spare_value < spare_threshold) ||
                    (erase_value < erase_threshold);
  assign accept = cmd_strobe && (state == IDLE) &&
                  (cmd_opcode == OPC_HEALTH);
  // Gated by ce so a frozen cycle never counts as a byte handed over
  assign take = ce && (state == SEND) && (!dout_valid || dout_ready);
  assign busy = (state == SEND);

  // Byte generator for the current position in the current sector
  always_comb begin
    next_byte = 8'h00;
    case (src)
      SRC_THR: begin
        if (byte_idx < THR_ENTRY_BASE) begin
          next_byte = half(THR_VERSION, byte_idx[0]);
        end else if (byte_idx == THR_CHECKSUM_BYTE) begin
          next_byte = 8'h00 - sum;
        end else if (ent < THR_ENTRIES) begin
          next_byte = thr_entry(ent, ent_off, spare_threshold,
                                erase_threshold);
        end
      end
      SRC_REMAP: begin
        if (byte_idx[8:1] < REMAP_CUR_WORD) begin
          next_byte = half(spare_init[byte_idx[4:1]], byte_idx[0]);
        end else if (byte_idx[8:1] < REMAP_END_WORD) begin
          next_byte = half(spare_cur[byte_idx[4:1]], byte_idx[0]);
        end
      end
      SRC_WEAR: begin
        next_byte = half(hist[{sector_idx, byte_idx[8:1]}],
                         byte_idx[0]);
      end
      default: next_byte = 8'h00;
    endcase
  end

  // Command decode and sequencing of sectors
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state <= IDLE;
      src <= SRC_THR;
      sector_last <= 2'h0;
      status_load <= 1'b0;
      cmd_abort <= 1'b0;
      cyl_lo_out <= 8'h00;
      cyl_hi_out <= 8'h00;
    end else if (ce) begin
      status_load <= 1'b0;
      cmd_abort <= 1'b0;
      if (accept) begin
        // Signature check aborts health commands lacking the 4Fh/C2h key; foreign opcodes never get here
        if (cmd_cyl_lo != SIG_OK_LO || cmd_cyl_hi != SIG_OK_HI) begin
          cmd_abort <= 1'b1;
        end else begin
          case (cmd_feature)
            FEAT_STATUS: begin
              status_load <= 1'b1;
              cyl_lo_out <= exceeded ? SIG_BAD_LO : SIG_OK_LO;
              cyl_hi_out <= exceeded ? SIG_BAD_HI : SIG_OK_HI;
            end
            FEAT_THRESH: begin
              state <= SEND;
              src <= SRC_THR;
              sector_last <= 2'h0;
            end
            FEAT_REMAP: begin
              if (cmd_sector_count == REMAP_SECTORS) begin
                state <= SEND;
                src <= SRC_REMAP;
                sector_last <= 2'h0;
              end else begin
                cmd_abort <= 1'b1;
              end
            end
            FEAT_WEAR: begin
              if (cmd_sector_count == WEAR_SECTORS) begin
                state <= SEND;
                src <= SRC_WEAR;
                sector_last <= 2'h3;
              end else begin
                cmd_abort <= 1'b1;
              end
            end
            default: cmd_abort <= 1'b1;
          endcase
        end
      end else if (take && byte_idx == SECTOR_LAST_BYTE &&
                   sector_idx == sector_last) begin
        state <= IDLE;
      end
    end
  end

  // Byte position, entry position and running checksum
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      byte_idx <= 9'h000;
      sector_idx <= 2'h0;
      ent <= 5'h00;
      ent_off <= 4'h0;
      sum <= 8'h00;
    end else if (ce) begin
      if (accept) begin
        byte_idx <= 9'h000;
        sector_idx <= 2'h0;
        ent <= 5'h00;
        ent_off <= 4'h0;
        sum <= 8'h00;
      end else if (take) begin
        byte_idx <= byte_idx + 9'h001;
        sum <= sum + next_byte;
        if (byte_idx == SECTOR_LAST_BYTE) begin
          sector_idx <= sector_idx + 2'h1;
        end
        if (byte_idx >= THR_ENTRY_BASE && ent < THR_ENTRIES) begin
          if (ent_off == THR_ENTRY_LAST) begin
            ent_off <= 4'h0;
            ent <= ent + 5'h01;
          end else begin
            ent_off <= ent_off + 4'h1;
          end
        end
      end
    end
  end

  // Output register; holds its byte until the host takes it
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      dout <= 8'h00;
      dout_valid <= 1'b0;
      sector_end <= 1'b0;
    end else if (ce) begin
      sector_end <= 1'b0;
      if (take) begin
        dout <= next_byte;
        dout_valid <= 1'b1;
        sector_end <= (byte_idx == SECTOR_LAST_BYTE);
      end else if (dout_ready) begin
        dout_valid <= 1'b0;
      end
    end
  end

  // Wear histogram; a placement wins over a same-cycle erase
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < CLASSES; i++) begin
        hist[i] <= 16'h0000;
      end
      blk_moved <= 1'b0;
    end else if (ce) begin
      blk_moved <= 1'b0;
      if (blk_place) begin
        hist[blk_place_class] <= hist[blk_place_class] + 16'h0001;
      end else if (blk_erase && step) begin
        hist[blk_class] <= hist[blk_class] - 16'h0001;
        hist[blk_class + 10'h001] <= hist[blk_class + 10'h001] + 16'h0001;
        blk_moved <= 1'b1;
      end
    end
  end

  a_status_bad: assert property (
    ce && accept && cmd_cyl_lo == SIG_OK_LO && cmd_cyl_hi == SIG_OK_HI &&
    cmd_feature == FEAT_STATUS && exceeded |=> status_load &&
    cyl_lo_out == 8'hf4 && cyl_hi_out == 8'h2c)
    else $error("bad status signature wrong");
  a_status_good: assert property (
    ce && accept && cmd_cyl_lo == SIG_OK_LO && cmd_cyl_hi == SIG_OK_HI &&
    cmd_feature == FEAT_STATUS && !exceeded |=> status_load &&
    cyl_lo_out == 8'h4f && cyl_hi_out == 8'hc2)
    else $error("good status signature wrong");
  a_sig_check: assert property (
    ce && accept && (cmd_cyl_lo != 8'h4f || cmd_cyl_hi != 8'hc2)
    |=> cmd_abort && !busy)
    else $error("command taken without signature");
  a_remap_count: assert property (
    ce && accept && cmd_cyl_lo == SIG_OK_LO && cmd_cyl_hi == SIG_OK_HI &&
    cmd_feature == FEAT_REMAP && cmd_sector_count != 8'h01
    |=> cmd_abort && !busy)
    else $error("remap started with bad count");
  a_thr_version: assert property (
    take && src == SRC_THR && byte_idx == 9'h000
    |=> dout == 8'h04)
    else $error("threshold version byte wrong");
  a_thr_ids: assert property (
    take && src == SRC_THR && byte_idx == 9'h00e
    |=> dout == 8'he5)
    else $error("erase entry identifier wrong");
  a_thr_zero: assert property (
    take && src == SRC_THR && byte_idx == 9'h01b
    |=> dout == 8'h00)
    else $error("no-threshold entry not zero");
  a_spare_entry: assert property (
    take && src == SRC_THR && byte_idx == 9'h003
    |=> dout == $past(spare_threshold))
    else $error("spare threshold byte wrong");
  a_checksum: assert property (
    take && src == SRC_THR && byte_idx == 9'h1ff
    |=> dout == 8'h00 - $past(sum))
    else $error("threshold checksum wrong");
  a_remap_resv: assert property (
    take && src == SRC_REMAP && byte_idx >= 9'h040
    |=> dout == 8'h00)
    else $error("remap reserved byte not zero");
  a_wear_end: assert property (
    take && src == SRC_WEAR && byte_idx == 9'h1ff && sector_idx == 2'h3
    |=> !busy)
    else $error("wear transfer length wrong");
  a_exempt_stay: assert property (
    ce && !blk_place && blk_erase && blk_class >= 10'h3fe
    |=> !blk_moved)
    else $error("block left last class");
  a_class_move: assert property (
    ce && !blk_place && blk_erase && blk_class == 10'h000 &&
    blk_erase_count == {16'h0000, wear_threshold} + 32'h1
    |=> blk_moved)
    else $error("block did not move class");
  a_exceed_cmp: assert property (
    spare_value < spare_threshold |-> exceeded)
    else $error("spare exceed not seen");
endmodule : health_responder

/* File: hdl/health_pkg.sv */
// Purpose: Shared constants for the drive-health subcommand responder
// Assumes: Task file values arrive already decoded from the host bus
// Notes: Multi-byte fields of the data sectors are sent low byte first
package health_pkg;
  // Command and feature codes
  localparam logic [7:0] OPC_HEALTH = 8'hb0;
  localparam logic [7:0] FEAT_THRESH = 8'hd1;
  localparam logic [7:0] FEAT_STATUS = 8'hda;
  localparam logic [7:0] FEAT_REMAP = 8'he0;
  localparam logic [7:0] FEAT_WEAR = 8'he1;
  // Signatures in the cylinder registers
  localparam logic [7:0] SIG_OK_LO = 8'h4f;
  localparam logic [7:0] SIG_OK_HI = 8'hc2;
  localparam logic [7:0] SIG_BAD_LO = 8'hf4;
  localparam logic [7:0] SIG_BAD_HI = 8'h2c;
  // Sector counts the host must give
  localparam logic [7:0] REMAP_SECTORS = 8'h01;
  localparam logic [7:0] WEAR_SECTORS = 8'h04;
  // Threshold sector layout
  localparam logic [15:0] THR_VERSION = 16'h0004;
  localparam logic [8:0] THR_ENTRY_BASE = 9'h002;
  localparam logic [4:0] THR_ENTRIES = 5'h1e;
  localparam logic [3:0] THR_ENTRY_LAST = 4'hb;
  localparam logic [8:0] THR_CHECKSUM_BYTE = 9'h1ff;
  localparam logic [7:0] ID_SPARE = 8'hc4;
  localparam logic [7:0] ID_ERASE = 8'he5;
  localparam logic [7:0] ID_ECC_TOTAL = 8'hcb;
  localparam logic [7:0] ID_ECC_CORR = 8'hcc;
  localparam logic [7:0] ID_READS = 8'he8;
  localparam logic [7:0] ID_UDMA_CRC = 8'hc7;
  // Remap sector layout, in 16-bit words
  localparam int CHIPS = 16;
  localparam logic [7:0] REMAP_CUR_WORD = 8'h10;
  localparam logic [7:0] REMAP_END_WORD = 8'h20;
  // Wear-level classes
  localparam int CLASSES = 1024;
  localparam logic [9:0] CLASS_LAST_LEVELLED = 10'h3fe;
  localparam logic [9:0] CLASS_EXEMPT = 10'h3ff;
  localparam logic [8:0] SECTOR_LAST_BYTE = 9'h1ff;
endpackage : health_pkg

/* File: hdl/wear_class_step.sv */
// Purpose: Decide whether an erase carries a block into the next class
// Assumes: erase_count is the block's count after the erase just done
// Notes: A class spans threshold+1 erase counts, so class c ends at
//        (c+1)*(threshold+1); the exempt class never moves
module wear_class_step
  import health_pkg::*;
(
  // Block being erased
  input wire logic [31:0] erase_count,
  input wire logic [9:0] cur_class,
  // Preformat setting
  input wire logic [15:0] wear_threshold,
  // Result
  output logic step
);
  logic [42:0] boundary;

  // Product is wide enough for any class and threshold
  assign boundary = ({33'h0, cur_class} + 43'h1) *
                    ({27'h0, wear_threshold} + 43'h1);

  // Stop at the last levelled class; exempt blocks stay put
  assign step = (cur_class < CLASS_LAST_LEVELLED) &&
                ({11'h0, erase_count} == boundary);
endmodule : wear_class_step

/* File: dv/ata_host.sv */
// Purpose: Host-side model that writes commands and drains sectors
// Assumes: Device answers on mclk; ready is sampled at rising edges
// Notes: Slow mode drops ready every other cycle to stall the stream
module ata_host
  import health_pkg::*;
(
  // Clock
  input wire logic mclk,
  // Task file
  output logic cmd_strobe,
  output logic [7:0] cmd_opcode,
  output logic [7:0] cmd_feature,
  output logic [7:0] cmd_cyl_lo,
  output logic [7:0] cmd_cyl_hi,
  output logic [7:0] cmd_sector_count,
  // Sector stream
  input wire logic [7:0] dout,
  input wire logic dout_valid,
  output logic dout_ready,
  input wire logic sector_end
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] rx [2048];
  int n_rx;
  int n_end;

  // Idle task file at time zero
  initial begin
    cmd_strobe = 1'b0;
    cmd_opcode = 8'h00;
    cmd_feature = 8'h00;
    cmd_cyl_lo = 8'h00;
    cmd_cyl_hi = 8'h00;
    cmd_sector_count = 8'h00;
    dout_ready = 1'b0;
  end

  // Signature, count and feature go out with the opcode write
  task automatic issue(input logic [7:0] op, f, cnt, lo, hi);
    @(posedge mclk);
    cmd_opcode <= op;
    cmd_feature <= f;
    cmd_sector_count <= cnt;
    cmd_cyl_lo <= lo;
    cmd_cyl_hi <= hi;
    cmd_strobe <= 1'b1;
    @(posedge mclk);
    cmd_strobe <= 1'b0;
    // Released fields show no stale value
    cmd_opcode <= ~op;
    cmd_feature <= ~f;
  endtask : issue

  // Bounded drain; a byte counts only where valid and ready meet
  task automatic take(input int n, input bit slow);
    n_rx = 0;
    n_end = 0;
    for (int i = 0; i < 3 * n + 20 && n_rx < n; i++) begin
      @(posedge mclk);
      if (dout_valid && dout_ready) begin
        rx[n_rx] = dout;
        n_rx++;
      end
      if (sector_end) n_end++;
      // Drop ready in the same step the last byte lands; no double drive
      if (n_rx < n) dout_ready <= slow ? ~dout_ready : 1'b1;
      else dout_ready <= 1'b0;
    end
  endtask : take
endmodule : ata_host

/* File: dv/smart_threshold_wear_report_test.sv */
// Purpose: Self-checking bench for the drive-health responder
// Assumes: ata_host plays the host; ce is held high except for the frozen query in t_abort
// Notes: Expected sectors are rebuilt here from the sector layouts
module smart_threshold_wear_report_test
  import health_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, reset_n, ce, cmd_strobe, status_load, cmd_abort, busy;
  logic [7:0] cmd_opcode, cmd_feature, cmd_cyl_lo, cmd_cyl_hi;
  logic [7:0] cmd_sector_count, cyl_lo_out, cyl_hi_out, dout;
  logic dout_valid, dout_ready, sector_end, blk_place, blk_erase, blk_moved;
  logic [7:0] spare_value, spare_threshold, erase_value, erase_threshold;
  logic [15:0] spare_init [CHIPS];
  logic [15:0] spare_cur [CHIPS];
  logic [15:0] wear_threshold;
  logic [9:0] blk_place_class, blk_class;
  logic [31:0] blk_erase_count;
  logic [15:0] exp_hist [CLASSES];
  logic [7:0] exp_sec [512];
  int error_cnt = 0;
  int n_tests = 0;

  health_responder u_dut (.mclk(mclk), .reset_n(reset_n), .ce(ce),
    .cmd_strobe(cmd_strobe), .cmd_opcode(cmd_opcode),
    .cmd_feature(cmd_feature), .cmd_cyl_lo(cmd_cyl_lo),
    .cmd_cyl_hi(cmd_cyl_hi), .cmd_sector_count(cmd_sector_count),
    .status_load(status_load), .cyl_lo_out(cyl_lo_out),
    .cyl_hi_out(cyl_hi_out), .cmd_abort(cmd_abort), .busy(busy),
    .dout(dout), .dout_valid(dout_valid), .dout_ready(dout_ready),
    .sector_end(sector_end), .spare_value(spare_value),
    .spare_threshold(spare_threshold), .erase_value(erase_value),
    .erase_threshold(erase_threshold), .spare_init(spare_init),
    .spare_cur(spare_cur), .wear_threshold(wear_threshold),
    .blk_place(blk_place), .blk_place_class(blk_place_class),
    .blk_erase(blk_erase), .blk_class(blk_class),
    .blk_erase_count(blk_erase_count), .blk_moved(blk_moved));

  ata_host u_host (.mclk(mclk), .cmd_strobe(cmd_strobe),
    .cmd_opcode(cmd_opcode), .cmd_feature(cmd_feature),
    .cmd_cyl_lo(cmd_cyl_lo), .cmd_cyl_hi(cmd_cyl_hi),
    .cmd_sector_count(cmd_sector_count), .dout(dout),
    .dout_valid(dout_valid), .dout_ready(dout_ready),
    .sector_end(sector_end));

  // Compare tasks, one per result kind
  task automatic chk_byte(input string what, input logic [7:0] e, g);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask : chk_byte

  task automatic chk_bit(input string what, input logic e, g);
    chk_byte(what, {7'h00, e}, {7'h00, g});
  endtask : chk_bit

  task automatic give_verdict;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  // Drain n bytes; a stalled stream ends the run
  task automatic get(input int n, input bit slow);
    u_host.take(n, slow);
    chk_bit("stream done", 1'b1, u_host.n_rx == n);
    if (u_host.n_rx != n) give_verdict();
    #1;
    chk_bit("busy after", 1'b0, busy);
    chk_byte("sector ends", 8'(n / 512), 8'(u_host.n_end));
  endtask : get

  task automatic t_status;
    logic [7:0] sv [4] = '{8'h10, 8'h50, 8'h50, 8'h51};
    logic [7:0] st [4] = '{8'h11, 8'h50, 8'h50, 8'h50};
    logic [7:0] ev [4] = '{8'h50, 8'h20, 8'h50, 8'hff};
    logic [7:0] et [4] = '{8'h50, 8'h21, 8'h50, 8'h00};
    logic bad;
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      spare_value <= sv[i];
      spare_threshold <= st[i];
      erase_value <= ev[i];
      erase_threshold <= et[i];
      u_host.issue(OPC_HEALTH, FEAT_STATUS, 8'h00, 8'h4f, 8'hc2);
      #1;
      bad = sv[i] < st[i] || ev[i] < et[i];
      chk_bit("status_load", 1'b1, status_load);
      chk_byte("cyl_lo_out", bad ? 8'hf4 : 8'h4f, cyl_lo_out);
      chk_byte("cyl_hi_out", bad ? 8'h2c : 8'hc2, cyl_hi_out);
    end
  endtask : t_status

  // Bad signature, unknown feature, wrong counts, foreign opcode
  task automatic t_abort;
    logic [7:0] f [6] = '{FEAT_STATUS, 8'h55, FEAT_REMAP, FEAT_WEAR,
      FEAT_THRESH, FEAT_THRESH};
    logic [7:0] c [6] = '{8'h00, 8'h00, 8'h02, 8'h01, 8'h00, 8'h00};
    logic [7:0] lo [6] = '{8'h00, 8'h4f, 8'h4f, 8'h4f, 8'h4e, 8'h4f};
    logic [7:0] hi [6] = '{8'hc2, 8'hc2, 8'hc2, 8'hc2, 8'hc2, 8'hc3};
    for (int i = 0; i < 6; i++) begin
      u_host.issue(OPC_HEALTH, f[i], c[i], lo[i], hi[i]);
      #1;
      chk_bit("cmd_abort", 1'b1, cmd_abort);
      chk_bit("busy", 1'b0, busy);
    end
    u_host.issue(8'hb1, FEAT_STATUS, 8'h00, 8'h4f, 8'hc2);
    #1;
    chk_bit("foreign status", 1'b0, status_load | cmd_abort);
    // A frozen block must ignore even a well-formed query
    @(posedge mclk);
    ce <= 1'b0;
    u_host.issue(OPC_HEALTH, FEAT_STATUS, 8'h00, 8'h4f, 8'hc2);
    #1;
    chk_bit("frozen status", 1'b0, status_load | cmd_abort);
    @(posedge mclk);
    ce <= 1'b1;
  endtask : t_abort

  task automatic t_thresh;
    logic [7:0] ids [6] = '{8'hc4, 8'he5, 8'hcb, 8'hcc, 8'he8, 8'hc7};
    logic [7:0] sum;
    @(posedge mclk);
    spare_threshold <= 8'h5a;
    erase_threshold <= 8'h3c;
    foreach (exp_sec[i]) exp_sec[i] = 8'h00;
    exp_sec[0] = 8'h04;
    for (int e = 0; e < 6; e++) exp_sec[2 + 12 * e] = ids[e];
    exp_sec[3] = 8'h5a;
    exp_sec[15] = 8'h3c;
    sum = 8'h00;
    for (int i = 0; i < 511; i++) sum += exp_sec[i];
    exp_sec[511] = -sum;
    u_host.issue(OPC_HEALTH, FEAT_THRESH, 8'h00, 8'h4f, 8'hc2);
    #1;
    chk_bit("busy", 1'b1, busy);
    get(512, 1'b1);
    for (int i = 0; i < 512; i++)
      chk_byte("thr byte", exp_sec[i],
        u_host.rx[i]);
  endtask : t_thresh

  task automatic t_remap;
    @(posedge mclk);
    foreach (exp_sec[i]) exp_sec[i] = 8'h00;
    for (int c = 0; c < CHIPS; c++) begin
      spare_init[c] <= 16'h0100 + 16'(c);
      spare_cur[c] <= 16'ha000 + 16'(c);
      exp_sec[2 * c] = 8'(c);
      exp_sec[2 * c + 1] = 8'h01;
      exp_sec[32 + 2 * c] = 8'(c);
      exp_sec[33 + 2 * c] = 8'ha0;
    end
    u_host.issue(OPC_HEALTH, FEAT_REMAP, 8'h01, 8'h4f, 8'hc2);
    get(512, 1'b0);
    for (int i = 0; i < 512; i++)
      chk_byte("remap byte", exp_sec[i], u_host.rx[i]);
  endtask : t_remap

  // One place or erase event, then the move flag
  task automatic blk_ev(input bit pl, input logic [9:0] cls,
      input logic [31:0] cnt, input bit mv);
    @(posedge mclk);
    blk_place <= pl;
    blk_erase <= !pl;
    blk_place_class <= cls;
    blk_class <= cls;
    blk_erase_count <= cnt;
    @(posedge mclk);
    blk_place <= 1'b0;
    blk_erase <= 1'b0;
    #1;
    chk_bit("blk_moved", mv, blk_moved);
  endtask : blk_ev

  // Threshold 3: a class spans four erases
  task automatic t_wear;
    @(posedge mclk);
    wear_threshold <= 16'h0003;
    foreach (exp_hist[i]) exp_hist[i] = 16'h0000;
    for (int i = 0; i < 3; i++) blk_ev(1'b1, 10'h000, 32'h0, 1'b0);
    blk_ev(1'b1, 10'h12c, 32'h0, 1'b0);
    blk_ev(1'b1, 10'h3fe, 32'h0, 1'b0);
    blk_ev(1'b1, 10'h3ff, 32'h0, 1'b0);
    blk_ev(1'b1, 10'h3ff, 32'h0, 1'b0);
    blk_ev(1'b0, 10'h000, 32'h3, 1'b0);
    blk_ev(1'b0, 10'h000, 32'h4, 1'b1);
    blk_ev(1'b0, 10'h001, 32'h8, 1'b1);
    blk_ev(1'b0, 10'h3fe, 32'hffc, 1'b0);
    blk_ev(1'b0, 10'h3ff, 32'h1000, 1'b0);
    exp_hist[0] = 16'h0002;
    exp_hist[2] = 16'h0001;
    exp_hist[300] = 16'h0001;
    exp_hist[1022] = 16'h0001;
    exp_hist[1023] = 16'h0002;
    u_host.issue(OPC_HEALTH, FEAT_WEAR, 8'h04, 8'h4f, 8'hc2);
    get(2048, 1'b0);
    for (int i = 0; i < 2048; i++)
      chk_byte("wear byte", exp_hist[i / 2][8 * (i % 2) +: 8],
        u_host.rx[i]);
  endtask : t_wear

  // Free-running clock, 50 ns period
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Main sequence
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    spare_value = 8'h50;
    spare_threshold = 8'h00;
    erase_value = 8'h50;
    erase_threshold = 8'h00;
    foreach (spare_init[i]) spare_init[i] = 16'h0000;
    foreach (spare_cur[i]) spare_cur[i] = 16'h0000;
    wear_threshold = 16'h0003;
    blk_place = 1'b0;
    blk_erase = 1'b0;
    blk_place_class = 10'h000;
    blk_class = 10'h000;
    blk_erase_count = 32'h0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk_byte("cyl_lo_out", 8'h00, cyl_lo_out);
    t_status();
    t_abort();
    t_thresh();
    t_remap();
    t_wear();
    give_verdict();
  end
endmodule : smart_threshold_wear_report_test
